// ---- rgc_pkg.sv ----
/*
  package of the ramp generator configuration register bank: offsets, field
  layouts, reset values, code tables and timing figures.
  assumes a 32-bit apb master on the same clock as the bank.
*/
package rgc_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] RGC_OFS_START_VOLTAGE_SELECT  = 12'h000;
  localparam logic [11:0] RGC_OFS_SLOPE_CURRENT_CONTROL = 12'h004;
  localparam logic [11:0] RGC_OFS_RISING_TIMING_SELECT  = 12'h008;
  localparam logic [11:0] RGC_OFS_STATUS                = 12'h00c;

  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam int          RGC_VSEL_W     = 4;
  localparam int          RGC_ISET_W     = 5;
  localparam int          RGC_RSRC_W     = 4;
  localparam int          RGC_SLOPE_W    = 5;
  localparam logic [3:0]  RGC_VSEL_RESET = 4'h0;
  localparam logic [4:0]  RGC_ISET_RESET = 5'h00;
  localparam logic [3:0]  RGC_RSRC_RESET = 4'h0;
  localparam int          RGC_STAT_VLD   = 0;
  localparam int          RGC_STAT_DISC  = 1;
  localparam int          RGC_STAT_PIN   = 2;

  // ---------------------------------------------------------------
  // start voltage codes
  // ---------------------------------------------------------------
  localparam logic [3:0]  RGC_VSEL_LAST_DIRECT = 4'h6;
  localparam logic [3:0]  RGC_VSEL_RESERVED_A  = 4'h7;
  localparam logic [3:0]  RGC_VSEL_SWITCHED_0  = 4'h8;
  localparam logic [3:0]  RGC_VSEL_SWITCHED_1  = 4'h9;

  // ---------------------------------------------------------------
  // current code table: 0.5 ua steps up to fh, 1 ua steps above
  // currents held in half microamperes; slope in 0.05 v/us units
  // ---------------------------------------------------------------
  localparam logic [4:0]  RGC_ISET_FINE_LAST = 5'h0f;
  localparam logic [5:0]  RGC_HALF_UA_BASE   = 6'h04;
  localparam logic [5:0]  RGC_HALF_UA_COARSE = 6'h14;
  localparam logic [5:0]  RGC_HALF_UA_MAX    = 6'h32;

  // ---------------------------------------------------------------
  // timing source code that selects the external pin
  // ---------------------------------------------------------------
  localparam logic [3:0]  RGC_RSRC_PIN = 4'h7;

  // ---------------------------------------------------------------
  // apb response timing
  // ---------------------------------------------------------------
  localparam int          RGC_CLK_MHZ    = 250;
  localparam int          RGC_WAIT_CYCLES = 0;

endpackage : rgc_pkg

// ---- rgc_ramp_generator_config_regs.sv ----
/*
  apb register bank of one ramp generator: start voltage select, slope
  current code and rising timing source select, with decoded outputs to the
  analog ramp circuitry.
  assumes apb signals come from logic on clk, but not the amplifier override level;
  the override level is treated as asynchronous and synchronised here.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
// Function
// R1: 4-bit start voltage code, reserved codes select nothing
// R2: switched inputs open while amplifier override tristates; output opens three enabled clocks after it rises
// R3: 5-bit current code, two step ranges
// R4: slope follows current at 0.1 v/us per ua
// R5: 4-bit rising timing source select field
// R6: unimplemented upper bits read as zero
// R7: all fields clear on every reset
// R8: source code 0111 selects external pin input
// R9: writes ignore upper bits, fields drive next cycle
module rgc_ramp_generator_config_regs
  import rgc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        amp_override_tristate,
  output logic      [3:0]  start_voltage_code,
  output logic             start_voltage_valid,
  output logic             start_switch_closed,
  output logic      [4:0]  current_code,
  output logic      [5:0]  current_half_ua,
  output logic      [5:0]  slope_step,
  output logic      [3:0]  rising_source_code,
  output logic             rising_pin_selected
);

  // ---------------------------------------------------------------
  // stored fields
  // ---------------------------------------------------------------
  logic [3:0] start_voltage_select;
  logic [4:0] slope_current_control;
  logic [3:0] rising_timing_source_select;
  logic       ovr_meta;
  logic       ovr_sync;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire        setup_phase = psel & ~penable;
  wire        access      = psel & penable & pready;
  wire        hit_vsel    = (paddr == RGC_OFS_START_VOLTAGE_SELECT);
  wire        hit_iset    = (paddr == RGC_OFS_SLOPE_CURRENT_CONTROL);
  wire        hit_rsrc    = (paddr == RGC_OFS_RISING_TIMING_SELECT);
  wire        hit_stat    = (paddr == RGC_OFS_STATUS);
  wire        mapped      = hit_vsel | hit_iset | hit_rsrc | hit_stat;
  wire        bad_write   = hit_stat & pwrite;
  wire        wr_ok       = access & pwrite & mapped & ~bad_write & pstrb[0];
  wire        wr_vsel     = wr_ok & hit_vsel;
  wire        wr_iset     = wr_ok & hit_iset;
  wire        wr_rsrc     = wr_ok & hit_rsrc;

  // ---------------------------------------------------------------
  // decoded analog controls
  // ---------------------------------------------------------------
  wire        vsel_direct   = (start_voltage_select <= RGC_VSEL_LAST_DIRECT); // [R1]
  wire        vsel_switched = (start_voltage_select == RGC_VSEL_SWITCHED_0) |
                              (start_voltage_select == RGC_VSEL_SWITCHED_1); // [R1]
  wire        vsel_valid    = vsel_direct | vsel_switched; // [R1]
  wire        switch_closed = vsel_switched & ~ovr_sync; // [R2]
  wire        iset_fine     = (slope_current_control <= RGC_ISET_FINE_LAST);
  wire [5:0]  half_ua_fine  = RGC_HALF_UA_BASE + {1'b0, slope_current_control}; // [R3]
  wire [5:0]  half_ua_crs   = RGC_HALF_UA_COARSE +
                              {1'b0, slope_current_control[3:0], 1'b0}; // [R3]
  wire [5:0]  half_ua       = iset_fine ? half_ua_fine : half_ua_crs; // [R3]
  wire        pin_sel       = (rising_timing_source_select == RGC_RSRC_PIN); // [R8]
  wire [31:0] stat_word;
  assign stat_word[31:3]          = 29'h0;
  assign stat_word[RGC_STAT_VLD]  = vsel_valid; // [R1]
  assign stat_word[RGC_STAT_DISC] = switch_closed; // [R2]
  assign stat_word[RGC_STAT_PIN]  = pin_sel; // [R8]

  // ---------------------------------------------------------------
  // read mux, upper bits zero
  // ---------------------------------------------------------------
  wire [31:0] rd_mux = hit_vsel ? {28'h0, start_voltage_select} :  // [R6]
                       hit_iset ? {27'h0, slope_current_control} : // [R6]
                       hit_rsrc ? {28'h0, rising_timing_source_select} : // [R6]
                       hit_stat ? stat_word : 32'h0;

  // ---------------------------------------------------------------
  // override synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_meta <= 1'b0;
      ovr_sync <= 1'b0;
    end else if (ce) begin
      ovr_meta <= amp_override_tristate;
      ovr_sync <= ovr_meta;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      start_voltage_select        <= RGC_VSEL_RESET; // [R7]
      slope_current_control       <= RGC_ISET_RESET; // [R7]
      rising_timing_source_select <= RGC_RSRC_RESET; // [R7]
    end else if (ce) begin
      if (wr_vsel) start_voltage_select <= pwdata[RGC_VSEL_W-1:0]; // [R1] [R9]
      if (wr_iset) slope_current_control <= pwdata[RGC_ISET_W-1:0]; // [R3] [R9]
      if (wr_rsrc) rising_timing_source_select <= pwdata[RGC_RSRC_W-1:0]; // [R5] [R9]
    end
  end

  // ---------------------------------------------------------------
  // apb response: zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup_phase;
      prdata  <= (setup_phase & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= setup_phase & (~mapped | bad_write);
    end
  end

  // ---------------------------------------------------------------
  // registered analog outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      start_voltage_code  <= 4'h0;
      start_voltage_valid <= 1'b0;
      start_switch_closed <= 1'b0;
      current_code        <= 5'h00;
      current_half_ua     <= 6'h00;
      slope_step          <= 6'h00;
      rising_source_code  <= 4'h0;
      rising_pin_selected <= 1'b0;
    end else if (ce) begin
      start_voltage_code  <= vsel_valid ? start_voltage_select : 4'h0; // [R1]
      start_voltage_valid <= vsel_valid; // [R1]
      start_switch_closed <= switch_closed; // [R2]
      current_code        <= slope_current_control; // [R3]
      current_half_ua     <= half_ua; // [R3]
      slope_step          <= half_ua; // [R4]
      rising_source_code  <= rising_timing_source_select; // [R5]
      rising_pin_selected <= pin_sel; // [R8]
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_RESERVED_NONE: assert property (@(posedge clk) disable iff (rst) // [R1]
    ce && (start_voltage_select == RGC_VSEL_RESERVED_A || start_voltage_select > RGC_VSEL_SWITCHED_1)
    |=> !start_voltage_valid && !start_switch_closed)
    else $error("reserved start code selected a source");

  AST_SWITCH_OPEN: assert property (@(posedge clk) disable iff (rst) // [R2]
    ce && ovr_sync |=> !start_switch_closed)
    else $error("switched input closed during override");

  AST_CURRENT_RANGE: assert property (@(posedge clk) disable iff (rst) // [R3]
    ce |=> current_half_ua <= RGC_HALF_UA_MAX &&
    (current_code != 5'h00 || current_half_ua == RGC_HALF_UA_BASE))
    else $error("current setting out of table");

  AST_CURRENT_TOP: assert property (@(posedge clk) disable iff (rst) // [R3]
    ce && slope_current_control == 5'h1f |=> current_half_ua == RGC_HALF_UA_MAX)
    else $error("top current code wrong");

  AST_SLOPE_TRACKS: assert property (@(posedge clk) disable iff (rst) // [R4]
    slope_step == current_half_ua)
    else $error("slope does not follow current");

  AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (rst) // [R5]
    ce && wr_rsrc ##1 ce |=> rising_source_code == $past(pwdata[3:0], 2))
    else $error("rising source write not presented");

  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst) // [R6]
    pready && psel && !pwrite && !hit_stat |-> prdata[31:5] == 27'h0)
    else $error("upper bits read nonzero");

  AST_RESET_CLEAR: assert property (@(posedge clk) // [R7]
    $past(rst) |-> start_voltage_select == 4'h0 && slope_current_control == 5'h00 &&
    rising_timing_source_select == 4'h0)
    else $error("fields not cleared by reset");

  AST_PIN_SELECT: assert property (@(posedge clk) disable iff (rst) // [R8]
    ce && rising_timing_source_select == RGC_RSRC_PIN |=> rising_pin_selected)
    else $error("pin code did not select pin");

  AST_HOLD: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && !wr_iset |=> $stable(slope_current_control))
    else $error("current code changed without write");

  // ---------------------------------------------------------------
  // start voltage and switch assertions
  // ---------------------------------------------------------------

  AST_START_CODE_MAP: assert property (@(posedge clk) disable iff (rst) // [R1]
    ce && vsel_valid |=> start_voltage_valid && start_voltage_code == $past(start_voltage_select))
    else $error("valid start code not presented");

  AST_RESERVED_CODE_ZERO: assert property (@(posedge clk) disable iff (rst) // [R1]
    ce && !vsel_valid |=> start_voltage_code == 4'h0)
    else $error("reserved start code presented");

  AST_SWITCH_CLOSE: assert property (@(posedge clk) disable iff (rst) // [R2]
    ce && vsel_switched && !ovr_sync |=> start_switch_closed)
    else $error("switched input not closed");

  AST_DIRECT_OPEN: assert property (@(posedge clk) disable iff (rst) // [R2]
    ce && !vsel_switched |=> !start_switch_closed)
    else $error("switch closed for direct source");

  // ---------------------------------------------------------------
  // current, slope and timing source assertions
  // ---------------------------------------------------------------

  AST_CURRENT_CODE_OUT: assert property (@(posedge clk) disable iff (rst) // [R3]
    ce |=> current_code == $past(slope_current_control))
    else $error("current code not presented");

  AST_CURRENT_FLOOR: assert property (@(posedge clk) disable iff (rst) // [R3]
    ce |=> current_half_ua >= RGC_HALF_UA_BASE)
    else $error("current below lowest setting");

  AST_SLOPE_BOTTOM: assert property (@(posedge clk) disable iff (rst) // [R4]
    ce && slope_current_control == 5'h00 |=> slope_step == RGC_HALF_UA_BASE)
    else $error("lowest slope wrong");

  AST_RISING_CODE_OUT: assert property (@(posedge clk) disable iff (rst) // [R5]
    ce |=> rising_source_code == $past(rising_timing_source_select))
    else $error("rising source code not presented");

  AST_PIN_ONLY: assert property (@(posedge clk) disable iff (rst) // [R8]
    ce && rising_timing_source_select != RGC_RSRC_PIN |=> !rising_pin_selected)
    else $error("pin selected by other code");

  // ---------------------------------------------------------------
  // bus and register assertions
  // ---------------------------------------------------------------

  AST_READY_PULSE: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && pready |=> !pready)
    else $error("ready held longer than one cycle");

  AST_MAPPED_OK: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && setup_phase && mapped && !bad_write |=> pready && !pslverr)
    else $error("mapped transfer not answered cleanly");

  AST_UNMAPPED_ERR: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && setup_phase && !mapped |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped transfer not refused");

  AST_STATUS_READONLY: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && setup_phase && bad_write |=> pready && pslverr)
    else $error("status write not refused");

  AST_SELECT_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst) // [R6]
    pready && psel && penable && !pwrite && (hit_vsel || hit_rsrc)
    |-> prdata[31:4] == 28'h0)
    else $error("select register upper bits nonzero");

  AST_WRITE_VSEL: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && wr_vsel |=> start_voltage_select == $past(pwdata[3:0]))
    else $error("start code write not taken");

  AST_WRITE_ISET: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && wr_iset |=> slope_current_control == $past(pwdata[4:0]))
    else $error("current code write not taken");

  AST_HOLD_VSEL: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && !wr_vsel |=> $stable(start_voltage_select))
    else $error("start code changed without write");

  AST_HOLD_RSRC: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && !wr_rsrc |=> $stable(rising_timing_source_select))
    else $error("rising source changed without write");

  AST_FREEZE: assert property (@(posedge clk) disable iff (rst) // [R9]
    !ce |=> $stable(start_voltage_code) && $stable(current_half_ua) &&
    $stable(rising_source_code) && $stable(pready) && $stable(start_switch_closed))
    else $error("state moved while clock enable low");

  AST_RESET_OUTPUTS: assert property (@(posedge clk) // [R7]
    $past(rst) |-> start_voltage_code == 4'h0 && current_code == 5'h00 &&
    rising_source_code == 4'h0 && !rising_pin_selected && !pready)
    else $error("outputs not cleared by reset");

endmodule : rgc_ramp_generator_config_regs

// ---- ramp_generator_config_regs_bench.sv ----
/*
  self-checking bench of the ramp generator configuration register bank.
  assumes the bank answers apb with pready and drives its decoded outputs on clk.
*/
module ramp_generator_config_regs_bench
  import rgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, start_voltage_code, rising_source_code;
  logic [4:0]  current_code;
  logic [5:0]  current_half_ua, slope_step, h;
  logic        amp_override_tristate, start_voltage_valid, start_switch_closed, rising_pin_selected, err, v;
  int          miscompares, n_tests;

  rgc_ramp_generator_config_regs i_rgc_ramp_generator_config_regs (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .amp_override_tristate(amp_override_tristate), .start_voltage_code(start_voltage_code),
    .start_voltage_valid(start_voltage_valid), .start_switch_closed(start_switch_closed),
    .current_code(current_code), .current_half_ua(current_half_ua), .slope_step(slope_step),
    .rising_source_code(rising_source_code), .rising_pin_selected(rising_pin_selected));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one transfer, then one idle cycle so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("rdata", e, rd);
    chk("read_err", 32'h0, 32'(err));
  endtask : rchk

  task automatic reset_all;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(RGC_OFS_START_VOLTAGE_SELECT, 32'h0);
    rchk(RGC_OFS_SLOPE_CURRENT_CONTROL, 32'h0);
    rchk(RGC_OFS_RISING_TIMING_SELECT, 32'h0);
    chk("outputs", 32'h0, 32'({start_voltage_code, current_code, rising_source_code, rising_pin_selected}));
  endtask : reset_all

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, amp_override_tristate} = '0;
    ce = 1'b1;
    pstrb = 4'hf;
    miscompares = 0;
    n_tests = 0;
    reset_all();
    for (int c = 0; c < 16; c++) begin
      v = (c <= 6) || c == 8 || c == 9;
      apb(1'b1, RGC_OFS_START_VOLTAGE_SELECT, 32'hffff_fff0 | 32'(c));
      repeat (2) @(posedge clk);
      chk("start_valid", 32'(v), 32'(start_voltage_valid));
      chk("start_code", v ? 32'(c) : 32'h0, 32'(start_voltage_code));
      chk("switch", 32'(c == 8 || c == 9), 32'(start_switch_closed));
      rchk(RGC_OFS_START_VOLTAGE_SELECT, 32'(c));
    end
    apb(1'b1, RGC_OFS_START_VOLTAGE_SELECT, 32'h0000_0008);
    repeat (2) @(posedge clk);
    rchk(RGC_OFS_STATUS, 32'h0000_0003);
    ce <= 1'b0;
    amp_override_tristate <= 1'b1;
    repeat (5) @(posedge clk);
    chk("switch_frozen", 32'h1, 32'(start_switch_closed));
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    chk("switch_ovr", 32'h0, 32'(start_switch_closed));
    rchk(RGC_OFS_STATUS, 32'h0000_0001);
    amp_override_tristate <= 1'b0;
    repeat (5) @(posedge clk);
    chk("switch_rel", 32'h1, 32'(start_switch_closed));
    for (int c = 0; c < 32; c++) begin
      h = (c <= 15) ? 6'(4 + c) : 6'(20 + 2 * (c - 16));
      apb(1'b1, RGC_OFS_SLOPE_CURRENT_CONTROL, 32'hffff_ffe0 | 32'(c));
      repeat (2) @(posedge clk);
      chk("current_code", 32'(c), 32'(current_code));
      chk("half_ua", 32'(h), 32'(current_half_ua));
      chk("slope", 32'(h), 32'(slope_step));
      rchk(RGC_OFS_SLOPE_CURRENT_CONTROL, 32'(c));
    end
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, RGC_OFS_RISING_TIMING_SELECT, 32'hffff_fff0 | 32'(c));
      repeat (2) @(posedge clk);
      chk("rise_code", 32'(c), 32'(rising_source_code));
      chk("rise_pin", 32'(c == 7), 32'(rising_pin_selected));
      rchk(RGC_OFS_RISING_TIMING_SELECT, 32'(c));
      rchk(RGC_OFS_STATUS, {29'h0, c == 7, 2'b11});
    end
    pstrb <= 4'h0;
    apb(1'b1, RGC_OFS_SLOPE_CURRENT_CONTROL, 32'h0000_0005);
    pstrb <= 4'hf;
    rchk(RGC_OFS_SLOPE_CURRENT_CONTROL, 32'h0000_001f);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, RGC_OFS_STATUS, 32'h0000_0007);
    chk("status_err", 32'h1, 32'(err));
    apb(1'b1, RGC_OFS_START_VOLTAGE_SELECT, 32'h0000_0003);
    reset_all();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

endmodule : ramp_generator_config_regs_bench
